// file: hw/mei_event_irq.v
// Event interrupt grouping and drive fault protection with an APB slave.
`timescale 1ns/100ps
`default_nettype none
`include "mei_regs.vh"

module mei_event_irq (
  input wire clk_sys,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`MEI_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] eventA,
  input wire [7:0] eventB,
  input wire [7:0] eventC,
  input wire [7:0] eventEnA,
  input wire [7:0] eventEnB,
  input wire [7:0] eventEnC,
  input wire driveFaultInput_n,
  input wire [15:0] driveOut,
  output wire [15:0] driveOutVal,
  output wire [15:0] driveOutEn,
  output reg irqGroupA,
  output reg irqGroupB,
  output reg irqGroupC
);

  // Phases of the register bus slave.
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_ACK = 1'b1;

  // One-hot mask of the lowest set bit, or zero when none is set.
  function [7:0] pickLowest;
    input [7:0] pend;
    integer i;
    begin
      pickLowest = 8'h00;
      for (i = 7; i >= 0; i = i - 1)
      begin
        if (pend[i])
        begin
          pickLowest = 8'h01 << i;
        end
      end
    end
  endfunction

  // Identifier of the lowest pending bit plus the group base, or zero.
  function [7:0] vectorId;
    input [7:0] pend;
    input [7:0] base;
    integer i;
    reg [7:0] id;
    begin
      id = 8'h00;
      for (i = 7; i >= 0; i = i - 1)
      begin
        if (pend[i])
        begin
          id = base + i[7:0];
        end
      end
      vectorId = id;
    end
  endfunction

  // Software clears first; a hardware set in the same cycle wins.
  function [7:0] updateFlags;
    input [7:0] flags;
    input [7:0] clr;
    input [7:0] set;
    begin
      updateFlags = (flags & ~clr) | set;
    end
  endfunction

  // Bits without a function read back as zero.
  function [31:0] widen;
    input [7:0] val;
    begin
      widen = {24'h000000, val};
    end
  endfunction

  // Register index match.
  function hitIdx;
    input [5:0] idx;
    input [5:0] want;
    begin
      hitIdx = (idx == want);
    end
  endfunction

  reg [0:0] apbState;
  reg [0:0] next_apbState;
  reg [7:0] maskA;
  reg [7:0] maskB;
  reg [7:0] maskC;
  reg [7:0] next_maskA;
  reg [7:0] next_maskB;
  reg [7:0] next_maskC;
  reg [7:0] flagA;
  reg [7:0] flagB;
  reg [7:0] flagC;
  reg [7:0] next_flagA;
  reg [7:0] next_flagB;
  reg [7:0] next_flagC;
  reg [7:0] clrA;
  reg [7:0] clrB;
  reg [7:0] clrC;
  reg [7:0] setA;
  reg [7:0] setB;
  reg [7:0] setC;
  reg [7:0] vecPickA;
  reg [7:0] vecPickB;
  reg [7:0] vecPickC;
  reg [`MEI_SYNC_LEN-1:0] faultSync;
  reg faultQual;
  reg [31:0] next_prdata;
  reg accErr;

  wire [5:0] wordIdx = paddr[7:2];
  wire apbAccess = psel && penable && !pready;
  wire apbDone = psel && penable && pready;
  wire apbRead = apbAccess && !pwrite;
  wire commitWrite = apbDone && pwrite;
  wire commitRead = apbDone && !pwrite;
  wire [7:0] pendA = flagA & maskA;
  wire [7:0] pendB = flagB & maskB;
  wire [7:0] pendC = flagC & maskC;

  // Bus phase: one wait state, then the answer stands for one cycle.
  always @*
  begin
    next_apbState = apbState;
    case (apbState)
      ST_IDLE:
      begin
        if (psel && penable)
        begin
          next_apbState = ST_ACK;
        end
      end
      ST_ACK:
      begin
        next_apbState = ST_IDLE;
      end
      default:
      begin
        next_apbState = ST_IDLE;
      end
    endcase
  end

  // Three stages; a change counts once stages two and three agree.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      faultSync <= {`MEI_SYNC_LEN{1'b1}};
      faultQual <= 1'b1;
    end
    else
    begin
      faultSync <= {faultSync[1:0], driveFaultInput_n};
      if (faultSync[2] == faultSync[1])
      begin
        faultQual <= faultSync[1];
      end
    end
  end

  // Qualified falling edge, seen at the fourth edge after the pin drops.
  wire faultFall = faultQual && !faultSync[2] && !faultSync[1];
  wire faultUnmasked = maskA[`MEI_FAULT_BIT];

  // The raw pin floats the drivers before synchronisation; a set flag holds.
  wire floatOut = faultUnmasked &&
    (!driveFaultInput_n || flagA[`MEI_FAULT_BIT]);
  assign driveOutVal = driveOut;
  assign driveOutEn = floatOut ? 16'h0000 : 16'hFFFF;

  // Enabled events set their flags; the fault sets bit zero of group A.
  always @*
  begin
    setA = eventA & eventEnA;
    setB = eventB & eventEnB;
    setC = eventC & eventEnC;
    if (faultFall)
    begin
      setA[`MEI_FAULT_BIT] = 1'b1;
    end
  end

  // Software clears: write one to a flag bit, or read the group vector.
  always @*
  begin
    clrA = 8'h00;
    clrB = 8'h00;
    clrC = 8'h00;
    if (commitWrite && hitIdx(wordIdx, `MEI_IDX_FLAG_A))
    begin
      clrA = pwdata[7:0];
    end
    if (commitWrite && hitIdx(wordIdx, `MEI_IDX_FLAG_B))
    begin
      clrB = pwdata[7:0];
    end
    if (commitWrite && hitIdx(wordIdx, `MEI_IDX_FLAG_C))
    begin
      clrC = pwdata[7:0];
    end
    if (commitRead && hitIdx(wordIdx, `MEI_IDX_VEC_A))
    begin
      clrA = clrA | vecPickA;
    end
    if (commitRead && hitIdx(wordIdx, `MEI_IDX_VEC_B))
    begin
      clrB = clrB | vecPickB;
    end
    if (commitRead && hitIdx(wordIdx, `MEI_IDX_VEC_C))
    begin
      clrC = clrC | vecPickC;
    end
  end

  always @*
  begin
    next_flagA = updateFlags(flagA, clrA, setA);
    next_flagB = updateFlags(flagB, clrB, setB);
    next_flagC = updateFlags(flagC, clrC, setC);
  end

  // Mask writes take effect at the edge that ends the transfer.
  always @*
  begin
    next_maskA = maskA;
    next_maskB = maskB;
    next_maskC = maskC;
    if (commitWrite && hitIdx(wordIdx, `MEI_IDX_MASK_A))
    begin
      next_maskA = pwdata[7:0];
    end
    if (commitWrite && hitIdx(wordIdx, `MEI_IDX_MASK_B))
    begin
      next_maskB = pwdata[7:0];
    end
    if (commitWrite && hitIdx(wordIdx, `MEI_IDX_MASK_C))
    begin
      next_maskC = pwdata[7:0];
    end
  end

  always @*
  begin
    next_prdata = 32'h00000000;
    accErr = 1'b0;
    case (wordIdx)
      `MEI_IDX_MASK_A: next_prdata = widen(maskA);
      `MEI_IDX_MASK_B: next_prdata = widen(maskB);
      `MEI_IDX_MASK_C: next_prdata = widen(maskC);
      `MEI_IDX_FLAG_A: next_prdata = widen(flagA);
      `MEI_IDX_FLAG_B: next_prdata = widen(flagB);
      `MEI_IDX_FLAG_C: next_prdata = widen(flagC);
      `MEI_IDX_VEC_A:
        next_prdata = widen(vectorId(pendA, `MEI_VBASE_A));
      `MEI_IDX_VEC_B:
        next_prdata = widen(vectorId(pendB, `MEI_VBASE_B));
      `MEI_IDX_VEC_C:
        next_prdata = widen(vectorId(pendC, `MEI_VBASE_C));
      default: accErr = 1'b1;
    endcase
  end

  // The id returned is held so the same flag is cleared at the last edge.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      vecPickA <= 8'h00;
      vecPickB <= 8'h00;
      vecPickC <= 8'h00;
    end
    else
    begin
      vecPickA <= (apbRead && hitIdx(wordIdx, `MEI_IDX_VEC_A)) ?
        pickLowest(pendA) : 8'h00;
      vecPickB <= (apbRead && hitIdx(wordIdx, `MEI_IDX_VEC_B)) ?
        pickLowest(pendB) : 8'h00;
      vecPickC <= (apbRead && hitIdx(wordIdx, `MEI_IDX_VEC_C)) ?
        pickLowest(pendC) : 8'h00;
    end
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      apbState <= ST_IDLE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      apbState <= next_apbState;
      pready <= (next_apbState == ST_ACK);
      pslverr <= apbAccess && accErr;
      prdata <= apbRead ? next_prdata : 32'h00000000;
    end
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      maskA <= `MEI_MASK_RST;
      maskB <= `MEI_MASK_RST;
      maskC <= `MEI_MASK_RST;
      flagA <= `MEI_FLAG_RST;
      flagB <= `MEI_FLAG_RST;
      flagC <= `MEI_FLAG_RST;
    end
    else
    begin
      maskA <= next_maskA;
      maskB <= next_maskB;
      maskC <= next_maskC;
      flagA <= next_flagA;
      flagB <= next_flagB;
      flagC <= next_flagC;
    end
  end

  // Requests follow the next flags and masks so they rise with the flag.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irqGroupA <= 1'b0;
      irqGroupB <= 1'b0;
      irqGroupC <= 1'b0;
    end
    else
    begin
      irqGroupA <= |(next_flagA & next_maskA);
      irqGroupB <= |(next_flagB & next_maskB);
      irqGroupC <= |(next_flagC & next_maskC);
    end
  end

endmodule
`default_nettype wire

// file: hw/mei_regs.vh
// Register offsets, field layouts and timing counts of the event interrupt block.
`ifndef MEI_REGS_VH
`define MEI_REGS_VH
// Register word indices; byte address is four times the index.
`define MEI_IDX_MASK_A 6'h2C
`define MEI_IDX_MASK_B 6'h2D
`define MEI_IDX_MASK_C 6'h2E
`define MEI_IDX_FLAG_A 6'h2F
`define MEI_IDX_FLAG_B 6'h30
`define MEI_IDX_FLAG_C 6'h31
`define MEI_IDX_VEC_A 6'h32
`define MEI_IDX_VEC_B 6'h33
`define MEI_IDX_VEC_C 6'h34
// Block window of 64 words.
`define MEI_WORDS 64
`define MEI_ADDR_W 8
// Number of sources in each group.
`define MEI_SRC 8
// Bit 0 of group A is the drive fault source.
`define MEI_FAULT_BIT 0
// Vector identifier bases; group A ids 1..8, B 9..16, C 17..24.
`define MEI_VBASE_A 8'h01
`define MEI_VBASE_B 8'h09
`define MEI_VBASE_C 8'h11
`define MEI_MASK_RST 8'h00
`define MEI_FLAG_RST 8'h00
// Synchroniser length in stages.
`define MEI_SYNC_LEN 3
`endif

// file: verification/mei_event_irq_properties.sv
// Port assertions for the event interrupt block.
`timescale 1ns/100ps
`default_nettype none
module mei_event_irq_properties (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic driveFaultInput_n,
  input wire logic [15:0] driveOutEn,
  input wire logic irqGroupA
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_ans; penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray");
  property p_top; prdata[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("top");
  property p_all; driveOutEn == 16'h0 || driveOutEn == 16'hFFFF; endproperty
  a_all: assert property (p_all) else $error("split");
  property p_hold; driveOutEn == 16'h0 |-> !driveFaultInput_n || irqGroupA;
  endproperty
  a_hold: assert property (p_hold) else $error("float");
  property p_flag; $fell(driveFaultInput_n) && driveOutEn == 16'h0 ##1
    !driveFaultInput_n [*4] |-> irqGroupA; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_rst; $rose(nrst) |-> !irqGroupA; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule
bind mei_event_irq mei_event_irq_properties i_mei_event_irq_properties (
  .clk_sys, .nrst, .penable, .pready, .prdata, .driveFaultInput_n,
  .driveOutEn, .irqGroupA);
`default_nettype wire

// file: verification/mei_cpu_model.sv
// Processor side that takes the three group requests.
`timescale 1ns/100ps
`default_nettype none
module mei_cpu_model (
  input wire logic clk_sys,
  input wire logic [2:0] irq,
  output logic [2:0] taken
);
  always @(posedge clk_sys) taken <= irq;
endmodule
`default_nettype wire

// file: verification/tb.sv
// Bench for the event interrupt block.
`timescale 1ns/100ps
`default_nettype none
`include "mei_regs.vh"
module tb;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic driveFaultInput_n = 1;
  logic [7:0] paddr = 0, eventA = 0, eventB = 0, eventC = 0;
  logic [7:0] eventEnA = 8'hFF, eventEnB = 8'hFF, eventEnC = 8'hFE;
  logic [31:0] pwdata = 0, rd;
  logic err;
  wire [15:0] driveOutVal;
  wire [2:0] taken;
  logic [15:0] driveOut = 16'h5A5A;
  wire [31:0] prdata;
  wire [15:0] driveOutEn;
  wire pready, pslverr, irqGroupA, irqGroupB, irqGroupC;
  int fails = 0, checked = 0;
  mei_event_irq i_mei_event_irq (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .eventA, .eventB, .eventC,
    .eventEnA, .eventEnB, .eventEnC, .driveFaultInput_n, .driveOut,
    .driveOutVal, .driveOutEn, .irqGroupA, .irqGroupB, .irqGroupC);
  mei_cpu_model i_mei_cpu_model (.clk_sys,
    .irq({irqGroupC, irqGroupB, irqGroupA}), .taken);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic cmp(input string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) $display("[ERR] %s exp %h got %h", nm, e, g);
    if (g !== e) fails++;
  endtask
  task automatic apb(input logic w, logic [5:0] i, logic [7:0] d);
    @(posedge clk_sys) {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 26'h0, d};
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (!pready);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 0;
  endtask
  task automatic rchk(input logic [5:0] i, logic [7:0] e);
    apb(0, i, 0);
    cmp("read", e, rd);
  endtask
  task test_done(input int extra);
    if (fails + extra == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial #100000 test_done(1);
  initial
  begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1;
    for (int i = 'h2C; i < 'h35; i++) rchk(i, 0);
    cmp("err", 0, err);
    rchk(6'h35, 0);
    cmp("err", 1, err);
    cmp("value", 16'h5A5A, driveOutVal);
    {eventA, eventB, eventC} <= 24'h802483;
    @(posedge clk_sys) {eventA, eventB, eventC} <= 0;
    rchk(`MEI_IDX_FLAG_C, 8'h82);
    for (int i = 0; i < 3; i++) apb(1, `MEI_IDX_MASK_A + i, 8'hA4);
    #1 cmp("irq", 7, {irqGroupC, irqGroupB, irqGroupA});
    @(posedge clk_sys) #1 cmp("taken", 7, taken);
    rchk(`MEI_IDX_VEC_A, 8'h08);
    rchk(`MEI_IDX_VEC_B, 8'h0B);
    rchk(`MEI_IDX_VEC_C, 8'h18);
    rchk(`MEI_IDX_FLAG_A, 8'h00);
    apb(1, `MEI_IDX_FLAG_C, 8'hFD);
    rchk(`MEI_IDX_FLAG_C, 8'h02);
    apb(1, `MEI_IDX_FLAG_C, 8'h02);
    rchk(`MEI_IDX_FLAG_C, 8'h00);
    apb(1, `MEI_IDX_MASK_A, 8'h01);
    driveFaultInput_n <= 0;
    #1 cmp("float", 0, driveOutEn);
    repeat (6) @(posedge clk_sys);
    driveFaultInput_n <= 1;
    #1 cmp("irqA", 1, irqGroupA);
    cmp("hold", 0, driveOutEn);
    rchk(`MEI_IDX_VEC_A, 8'h01);
    #1 cmp("drive", 16'hFFFF, driveOutEn);
    test_done(0);
  end
endmodule
`default_nettype wire
